//--- hdl/capcomp_unit.sv
// Capture/compare unit beside a 16-bit timer, with its AHB-Lite register file.
`timescale 1ns/1ns
`default_nettype none
`include "capcomp_defines.svh"
module capcomp_unit (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Timer
	input wire logic [15:0] timerValue,
	output logic timerClearReq,
	// Converter
	input wire logic convEnable,
	output logic convStart,
	// Pin
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	// Interrupt request level
	output logic irqRequest
);
	logic [31:0] rdAddr;
	logic [31:0] rdValue;
	logic wrEn;
	logic [31:0] wrAddr;
	logic [31:0] wrData;

	capcomp_pkg::mode_t mode_r;
	capcomp_pkg::hold_t hold_r;
	logic irqFlag_r;
	logic irqEnable_r;
	logic portLatch_r;
	logic pinDir_r;
	logic compareLatch_r;
	logic matchPrev_r;
	logic convStart_r;

	logic captureOn;
	logic compareOn;
	logic drivesPin;
	capcomp_pkg::edge_sel_e edgeSel;
	logic sampleLevel;
	logic captureEvent;
	logic match;
	logic matchEvent;
	logic wrControl;
	logic wrFlag;

	capcomp_ahb_slave u_slave (
		.refClk(ref_clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rdAddr(rdAddr),
		.rdValue(rdValue),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData)
	);

	// Mode decode. Codes with no meaning leave the unit idle, so a stray write parks it
	// with the prescaler cleared and the pin handed back to the port latch.
	always_comb begin
		captureOn = 1'b0;
		compareOn = 1'b0;
		drivesPin = 1'b0;
		edgeSel = capcomp_pkg::EDGE_FALL;
		case (mode_r)
			`CC_MODE_CAP_FALL: begin
				captureOn = 1'b1;
				edgeSel = capcomp_pkg::EDGE_FALL;
			end
			`CC_MODE_CAP_RISE: begin
				captureOn = 1'b1;
				edgeSel = capcomp_pkg::EDGE_RISE;
			end
			`CC_MODE_CAP_4TH: begin
				captureOn = 1'b1;
				edgeSel = capcomp_pkg::EDGE_RISE_4TH;
			end
			`CC_MODE_CAP_16TH: begin
				captureOn = 1'b1;
				edgeSel = capcomp_pkg::EDGE_RISE_16TH;
			end
			`CC_MODE_TOGGLE, `CC_MODE_SET, `CC_MODE_CLEAR: begin
				compareOn = 1'b1;
				drivesPin = 1'b1;
			end
			`CC_MODE_SWINT, `CC_MODE_TRIGGER: begin
				compareOn = 1'b1;
				drivesPin = 1'b0;
			end
			default: begin
				captureOn = 1'b0;
			end
		endcase
	end

	// Pin: direction bit high means input; the unit owns the data only in driving modes.
	// A control write of zero hands the pin straight back to the port latch.
	assign pinOe = ~pinDir_r;
	assign pinOut = drivesPin ? compareLatch_r : portLatch_r;

	// An output pin is watched through its own latch, so a port write is an edge.
	assign sampleLevel = pinDir_r ? pinIn : pinOut;

	capcomp_edge_prescaler u_prescaler (
		.refClk(ref_clk),
		.reset(reset),
		.captureOn(captureOn),
		.edgeSel(edgeSel),
		.sampleLevel(sampleLevel),
		.captureEvent(captureEvent)
	);

	// A match counts once when it appears, so a slow timer holding the value fires once.
	assign match = compareOn && (hold_r == timerValue);
	assign matchEvent = match && !matchPrev_r;

	// Dropping the match before the next timer tick cancels the pending clear.
	// The request is a level, not a pulse: the timer clears on its own next tick.
	assign timerClearReq = match && (mode_r == `CC_MODE_TRIGGER);
	assign convStart = convStart_r;
	assign irqRequest = irqFlag_r && irqEnable_r;

	assign wrControl = wrEn && (wrAddr == `CC_OFS_CONTROL);
	assign wrFlag = wrEn && (wrAddr == `CC_OFS_FLAG);

	// Remembers the previous cycle's match, so a match held over many cycles is one event.
	// A mode change carries the old mode's match over, so a switch between compare modes mid-match is quiet.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			matchPrev_r <= 1'b0;
		end else begin
			matchPrev_r <= match;
		end
	end

	// The start pulse is registered: the converter sees a clean one-cycle strobe, one
	// cycle after the trigger, and only for a match that is new in this mode.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			convStart_r <= 1'b0;
		end else begin
			convStart_r <= matchEvent && (mode_r == `CC_MODE_TRIGGER) && convEnable;
		end
	end

	// A mode change is taken as written; no capture is suppressed around it.
	// Software should mask the interrupt and clear the flag after changing the mode.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mode_r <= `CC_RST_MODE;
		end else if (wrControl) begin
			mode_r <= wrData[`CC_MODE_MSB:`CC_MODE_LSB];
		end
	end

	// Capture beats a software write to the hold pair in the same cycle.
	// The halves are written one at a time, so a compare value should be loaded with the
	// unit off; a half-written pair may match early and raise the flag.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hold_r <= `CC_RST_HOLD;
		end else if (captureEvent) begin
			hold_r <= timerValue;
		end else if (wrEn && (wrAddr == `CC_OFS_HOLD_LOW)) begin
			hold_r[7:0] <= wrData[7:0];
		end else if (wrEn && (wrAddr == `CC_OFS_HOLD_HIGH)) begin
			hold_r[15:8] <= wrData[7:0];
		end
	end

	// Hardware only sets the flag; a set in the clearing cycle wins.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irqFlag_r <= 1'b0;
		end else if (captureEvent || matchEvent) begin
			irqFlag_r <= 1'b1;
		end else if (wrFlag) begin
			irqFlag_r <= wrData[`CC_FLAG_BIT];
		end
	end

	// The enable only masks the request level; the flag goes on recording events.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irqEnable_r <= 1'b0;
		end else if (wrEn && (wrAddr == `CC_OFS_ENABLE)) begin
			irqEnable_r <= wrData[`CC_ENABLE_BIT];
		end
	end

	// Port register. Direction resets to input so the pin is not driven before software
	// has chosen; on an output pin a write to the latch is itself a capture edge.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			portLatch_r <= `CC_RST_LATCH;
			pinDir_r <= `CC_RST_DIR;
		end else if (wrEn && (wrAddr == `CC_OFS_PORT)) begin
			portLatch_r <= wrData[`CC_PORT_LATCH_BIT];
			pinDir_r <= wrData[`CC_PORT_DIR_BIT];
		end
	end

	// Compare output latch, apart from the port latch. A control write presets it.
	// Clear-on-match mode presets it high so that the match has a visible effect.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			compareLatch_r <= 1'b0;
		end else if (wrControl) begin
			compareLatch_r <= (wrData[`CC_MODE_MSB:`CC_MODE_LSB] == `CC_MODE_CLEAR);
		end else if (matchEvent) begin
			case (mode_r)
				`CC_MODE_TOGGLE: begin
					compareLatch_r <= ~compareLatch_r;
				end
				`CC_MODE_SET: begin
					compareLatch_r <= 1'b1;
				end
				`CC_MODE_CLEAR: begin
					compareLatch_r <= 1'b0;
				end
				default: begin
					compareLatch_r <= compareLatch_r;
				end
			endcase
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	// The pair is read one half at a time, so a capture between the two reads can mix two
	// events; software should read with the unit off or check the flag around the reads.
	always_comb begin
		rdValue = 32'h0000_0000;
		case (rdAddr)
			`CC_OFS_CONTROL: begin
				rdValue[`CC_MODE_MSB:`CC_MODE_LSB] = mode_r;
			end
			`CC_OFS_HOLD_LOW: begin
				rdValue[7:0] = hold_r[7:0];
			end
			`CC_OFS_HOLD_HIGH: begin
				rdValue[7:0] = hold_r[15:8];
			end
			`CC_OFS_FLAG: begin
				rdValue[`CC_FLAG_BIT] = irqFlag_r;
			end
			`CC_OFS_ENABLE: begin
				rdValue[`CC_ENABLE_BIT] = irqEnable_r;
			end
			`CC_OFS_PORT: begin
				rdValue[`CC_PORT_LATCH_BIT] = portLatch_r;
				rdValue[`CC_PORT_DIR_BIT] = pinDir_r;
				rdValue[`CC_PORT_LEVEL_BIT] = sampleLevel;
				rdValue[`CC_PORT_CMPLATCH_BIT] = compareLatch_r;
			end
			default: begin
				rdValue = 32'h0000_0000;
			end
		endcase
	end
endmodule : capcomp_unit
`default_nettype wire

//--- shared/capcomp_defines.svh
// Register offsets, field positions, reset values and mode codes of the capture/compare unit.
`ifndef CAPCOMP_DEFINES_SVH
`define CAPCOMP_DEFINES_SVH

`define CC_OFS_CONTROL 32'h0000_0000
`define CC_OFS_HOLD_LOW 32'h0000_0004
`define CC_OFS_HOLD_HIGH 32'h0000_0008
`define CC_OFS_FLAG 32'h0000_000C
`define CC_OFS_ENABLE 32'h0000_0010
`define CC_OFS_PORT 32'h0000_0014

`define CC_MODE_LSB 0
`define CC_MODE_MSB 3
`define CC_FLAG_BIT 0
`define CC_ENABLE_BIT 0
`define CC_PORT_LATCH_BIT 0
`define CC_PORT_DIR_BIT 1
`define CC_PORT_LEVEL_BIT 2
`define CC_PORT_CMPLATCH_BIT 3

`define CC_RST_MODE 4'h0
`define CC_RST_HOLD 16'h0000
`define CC_RST_DIR 1'b1
`define CC_RST_LATCH 1'b0

`define CC_MODE_OFF 4'h0
`define CC_MODE_TOGGLE 4'h2
`define CC_MODE_CAP_FALL 4'h4
`define CC_MODE_CAP_RISE 4'h5
`define CC_MODE_CAP_4TH 4'h6
`define CC_MODE_CAP_16TH 4'h7
`define CC_MODE_SET 4'h8
`define CC_MODE_CLEAR 4'h9
`define CC_MODE_SWINT 4'hA
`define CC_MODE_TRIGGER 4'hB

`define CC_PRESCALE_4TH_MASK 4'h3
`define CC_PRESCALE_16TH_MASK 4'hF

`define CC_HSIZE_WORD 3'h2

`endif

//--- shared/capcomp_pkg.sv
// Types shared by the capture/compare unit files.
package capcomp_pkg;
	typedef logic [3:0] mode_t;
	typedef logic [15:0] hold_t;
	typedef enum logic [2:0] {
		EDGE_FALL,
		EDGE_RISE,
		EDGE_RISE_4TH,
		EDGE_RISE_16TH
	} edge_sel_e;
endpackage : capcomp_pkg

//--- hdl/capcomp_edge_prescaler.sv
// Pin edge detector and capture prescaler.
`timescale 1ns/1ns
`default_nettype none
`include "capcomp_defines.svh"
module capcomp_edge_prescaler (
	// Clock and reset
	input wire logic refClk,
	input wire logic reset,
	// Control
	input wire logic captureOn,
	input wire capcomp_pkg::edge_sel_e edgeSel,
	input wire logic sampleLevel,
	// Result
	output logic captureEvent
);
	logic prevLevel_r;
	logic [3:0] count_r;
	logic rise;
	logic fall;

	assign rise = sampleLevel & ~prevLevel_r;
	assign fall = ~sampleLevel & prevLevel_r;

	always_ff @(posedge refClk or posedge reset) begin
		if (reset) begin
			prevLevel_r <= 1'b0;
		end else begin
			prevLevel_r <= sampleLevel;
		end
	end

	// The count survives a change between prescale settings, so a switch can fire early.
	always_ff @(posedge refClk or posedge reset) begin
		if (reset) begin
			count_r <= 4'h0;
		end else if (!captureOn) begin
			count_r <= 4'h0;
		end else if (rise) begin
			count_r <= count_r + 4'h1;
		end
	end

	always_comb begin
		captureEvent = 1'b0;
		if (captureOn) begin
			case (edgeSel)
				capcomp_pkg::EDGE_FALL: begin
					captureEvent = fall;
				end
				capcomp_pkg::EDGE_RISE: begin
					captureEvent = rise;
				end
				capcomp_pkg::EDGE_RISE_4TH: begin
					captureEvent = rise && ((count_r & `CC_PRESCALE_4TH_MASK)
						== `CC_PRESCALE_4TH_MASK);
				end
				capcomp_pkg::EDGE_RISE_16TH: begin
					captureEvent = rise && (count_r == `CC_PRESCALE_16TH_MASK);
				end
				default: begin
					captureEvent = 1'b0;
				end
			endcase
		end
	end
endmodule : capcomp_edge_prescaler
`default_nettype wire

//--- hdl/capcomp_ahb_slave.sv
// AHB-Lite slave front end: zero-wait single word transfers.
`timescale 1ns/1ns
`default_nettype none
`include "capcomp_defines.svh"
module capcomp_ahb_slave (
	// Clock and reset
	input wire logic refClk,
	input wire logic reset,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Register file side
	output logic [31:0] rdAddr,
	input wire logic [31:0] rdValue,
	output logic wrEn,
	output logic [31:0] wrAddr,
	output logic [31:0] wrData
);
	logic accept;
	logic wrPending_r;
	logic [31:0] wrAddr_r;
	logic [31:0] hrdata_r;

	// Only whole-word transfers are acted on; other sizes complete but do nothing.
	assign accept = hsel && htrans[1] && hready && (hsize == `CC_HSIZE_WORD);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rdAddr = haddr;
	assign hrdata = hrdata_r;
	assign wrEn = wrPending_r;
	assign wrAddr = wrAddr_r;
	assign wrData = hwdata;

	always_ff @(posedge refClk or posedge reset) begin
		if (reset) begin
			wrPending_r <= 1'b0;
			wrAddr_r <= 32'h0000_0000;
		end else begin
			wrPending_r <= accept && hwrite;
			if (accept && hwrite) begin
				wrAddr_r <= haddr;
			end
		end
	end

	// Read data is sampled at the address phase so it stands for the whole data phase.
	always_ff @(posedge refClk or posedge reset) begin
		if (reset) begin
			hrdata_r <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			hrdata_r <= rdValue;
		end
	end
endmodule : capcomp_ahb_slave
`default_nettype wire

//--- test/capcomp_checker_assertions.sv
// Port-level assertions for the capture/compare unit.
`timescale 1ns/1ns
`default_nettype none
module capcomp_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Timer, converter, pin and interrupt
	input wire logic [15:0] timerValue,
	input wire logic timerClearReq,
	input wire logic convEnable,
	input wire logic convStart,
	input wire logic pinOe,
	input wire logic irqRequest
);
	logic wrAct;
	logic rdAct;
	assign wrAct = hsel & htrans[1] & hwrite;
	assign rdAct = hsel & htrans[1] & !hwrite;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_resetQuiet;
		$fell(reset) |-> !pinOe && !convStart && !irqRequest && !timerClearReq;
	endproperty
	a_resetQuiet: assert property (p_resetQuiet) else $error("outputs busy after reset");
	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or not okay");
	property p_rdHold;
		$changed(hrdata) |-> $past(rdAct);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved without a read");
	property p_convCause;
		convStart |-> $past(timerClearReq) && !$past(timerClearReq, 2) && $past(convEnable);
	endproperty
	a_convCause: assert property (p_convCause) else $error("conversion start without match");
	property p_convFire;
		$rose(timerClearReq) && $changed(timerValue) && convEnable |=> convStart;
	endproperty
	a_convFire: assert property (p_convFire) else $error("match did not start conversion");
	// A hold write lands two cycles after its address phase, so that case is excused.
	property p_clearDrop;
		timerClearReq ##1 ($changed(timerValue) && !$past(wrAct, 2)) |-> !timerClearReq;
	endproperty
	a_clearDrop: assert property (p_clearDrop) else $error("trigger kept after timer moved");
	property p_clearHold;
		timerClearReq ##1 ($stable(timerValue) && !$past(wrAct, 2)) |-> timerClearReq;
	endproperty
	a_clearHold: assert property (p_clearHold) else $error("trigger lost while matching");
	property p_irqSticky;
		$fell(irqRequest) |-> $past(wrAct, 2);
	endproperty
	a_irqSticky: assert property (p_irqSticky) else $error("flag cleared by hardware");
	property p_oeByWrite;
		$changed(pinOe) |-> $past(wrAct, 2);
	endproperty
	a_oeByWrite: assert property (p_oeByWrite) else $error("pin direction moved alone");
endmodule : capcomp_checker
bind capcomp_unit capcomp_checker ccChk (.ref_clk, .reset, .hsel, .htrans, .hwrite,
	.hreadyout, .hresp, .hrdata, .timerValue, .timerClearReq, .convEnable, .convStart,
	.pinOe, .irqRequest);
`default_nettype wire

//--- test/capcomp_pin_model.sv
// Behavioural model of the signal source at the far side of the unit's pin.
`timescale 1ns/1ns
`default_nettype none
module capcomp_pin_model (
	// Unit side
	input wire logic pinOut,
	input wire logic pinOe,
	// Stimulus side
	input wire logic srcLevel,
	output logic pinLevel
);
	// The source backs off while the unit drives, so a port write is seen on the pin.
	assign pinLevel = pinOe ? pinOut : srcLevel;
endmodule : capcomp_pin_model
`default_nettype wire

//--- test/test_timer_capture_compare_unit.sv
// Self-checking testbench of the capture/compare unit.
`timescale 1ns/1ns
`default_nettype none
`include "capcomp_defines.svh"
module test_timer_capture_compare_unit;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] tv = 16'h0;
	logic ce = 1'b0;
	logic src = 1'b0;
	logic hreadyout, hresp, timerClearReq, convStart, pinIn, pinOut, pinOe, irqRequest;
	logic [31:0] hrdata;
	int failures = 0;
	int num_checks = 0;
	capcomp_unit dut (.ref_clk, .reset, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(`CC_HSIZE_WORD), .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
		.timerValue(tv), .timerClearReq, .convEnable(ce), .convStart, .pinIn, .pinOut,
		.pinOe, .irqRequest);
	capcomp_pin_model pin (.pinOut, .pinOe, .srcLevel(src), .pinLevel(pinIn));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			$display("Error at %0t: bus hang", $time);
			failures++;
			summarize();
		end
	endtask : wt
	task bw(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
	endtask : bw
	task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		wt();
		chk(hrdata & m, e);
	endtask : rd
	task ch(input logic [15:0] e);
		rd(`CC_OFS_HOLD_LOW, 32'hFF, {24'h0, e[7:0]});
		rd(`CC_OFS_HOLD_HIGH, 32'hFF, {24'h0, e[15:8]});
	endtask : ch
	// Pulses are a few cycles wide so every level is seen by the edge detector.
	task pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			src <= 1'b1;
			repeat (2) @(posedge ref_clk);
			src <= 1'b0;
			@(posedge ref_clk);
		end
		repeat (2) @(posedge ref_clk);
	endtask : pulse
	task tReset;
		rd(`CC_OFS_CONTROL, 32'hF, {28'h0, `CC_RST_MODE});
		rd(`CC_OFS_PORT, 32'h2, {30'h0, `CC_RST_DIR, 1'b0});
		ch(`CC_RST_HOLD);
		bw(32'h0000_0040, 32'hFFFF_FFFF);
		rd(32'h0000_0040, 32'hFFFF_FFFF, 32'h0);
		$display("reset test done");
	endtask : tReset
	task tCapture;
		logic [3:0] m;
		int n;
		for (int i = 0; i < 4; i++) begin
			m = `CC_MODE_CAP_FALL + 4'(i);
			n = (i < 2) ? 1 : (i == 2 ? 4 : 16);
			bw(`CC_OFS_CONTROL, 32'h0);
			bw(`CC_OFS_CONTROL, {28'h0, m});
			bw(`CC_OFS_FLAG, 32'h0);
			bw(`CC_OFS_ENABLE, 32'h1);
			for (int j = 0; j < 2; j++) begin
				tv <= {m, 4'(j), 8'hC3};
				pulse(n - 1);
				if (j == 0) rd(`CC_OFS_FLAG, 32'h1, 32'h0);
				pulse(1);
				rd(`CC_OFS_FLAG, 32'h1, 32'h1);
				chk(irqRequest, 1'b1);
				ch({m, 4'(j), 8'hC3});
			end
			bw(`CC_OFS_ENABLE, 32'h0);
		end
		$display("capture test done");
	endtask : tCapture
	task tPort;
		bw(`CC_OFS_CONTROL, 32'h0);
		bw(`CC_OFS_PORT, 32'h0);
		bw(`CC_OFS_CONTROL, {28'h0, `CC_MODE_CAP_RISE});
		bw(`CC_OFS_FLAG, 32'h0);
		tv <= 16'h5A0F;
		bw(`CC_OFS_PORT, 32'h1);
		rd(`CC_OFS_FLAG, 32'h1, 32'h1);
		chk(pinOe, 1'b1);
		ch(16'h5A0F);
		$display("port write test done");
	endtask : tPort
	task tCompare;
		logic [3:0] m;
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? `CC_MODE_SET : (i == 1 ? `CC_MODE_CLEAR : `CC_MODE_TOGGLE);
			tv <= 16'h0;
			bw(`CC_OFS_HOLD_LOW, 32'h34);
			bw(`CC_OFS_HOLD_HIGH, 32'h12);
			bw(`CC_OFS_CONTROL, {28'h0, m});
			bw(`CC_OFS_FLAG, 32'h0);
			rd(`CC_OFS_PORT, 32'h8, {28'h0, i == 1, 3'h0});
			tv <= 16'h1234;
			repeat (4) @(posedge ref_clk);
			tv <= 16'h0;
			rd(`CC_OFS_PORT, 32'h8, {28'h0, i != 1, 3'h0});
			#1 chk(pinOut, i != 1);
			rd(`CC_OFS_FLAG, 32'h1, 32'h1);
			bw(`CC_OFS_CONTROL, 32'h0);
			rd(`CC_OFS_PORT, 32'h8, 32'h0);
		end
		$display("compare test done");
	endtask : tCompare
	task tTrig;
		for (int i = 0; i < 3; i++) begin
			bw(`CC_OFS_CONTROL, {28'h0, i == 0 ? `CC_MODE_SWINT : `CC_MODE_TRIGGER});
			bw(`CC_OFS_FLAG, 32'h0);
			ce <= i != 2;
			tv <= 16'h1234;
			#1 chk(timerClearReq, i > 0);
			chk(convStart, 1'b0);
			@(posedge ref_clk);
			#1 chk(convStart, i == 1);
			chk(pinOut, 1'b1);
			@(posedge ref_clk);
			#1 chk(convStart, 1'b0);
			@(posedge ref_clk);
			tv <= 16'h0;
			rd(`CC_OFS_FLAG, 32'h1, 32'h1);
		end
		$display("trigger test done");
	endtask : tTrig
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		tReset();
		tCapture();
		tPort();
		tCompare();
		tTrig();
		summarize();
	end
endmodule : test_timer_capture_compare_unit
`default_nettype wire
